// File: core/scp_core.sv
// serial control port: SPI slave on sclk, two-wire slave and registers on ref_clk
// assumes pins arrive raw; the bench resolves tri-state lines from the enables
// Behaviour
// - instruction is the first 16 rising edges, then payload
// - top instruction bit: one reads, zero writes; then count bits
// - low 13 instruction bits give the start address
// - write bits sampled on rising edge into buffer registers
// - chip select high on byte boundary stalls a fixed-count frame, resume next byte
// - chip select high mid-byte returns port to idle
// - multibyte writes never skip addresses
// - one at 0x0005 bit 0 copies buffer to active, self-clears
// - update pin also copies; writes to 0x0000 and 0x0004 act at once, others only after update
// - only the 16-bit instruction form exists
// - read shifts out N bytes from the start address
// - read bits driven on falling edge
// - readback returns a byte for every address
// - 0x0004 bit 0 picks active or buffer readback
// - 0x0000 bit 6 selects LSB first for next operation
// - MSB first: address decrements per byte
// - LSB first: address increments per byte
// - two-wire side is slave only, never drives clock
// - two-wire inputs reject pulses under 50 ns
// - two-wire side uses a 16-bit register address
// - two-wire side answers only its own 7-bit address
// - streaming takes any byte count until chip select rises
// - chip select high floats both data outputs
// - data pin bidirectional after reset, separate output selectable
// - protocol choice latched at startup, changed only by reset
module scp_core
	import scp_pkg::*;
#(
	parameter int MEM_AW = 6
)(
	input  logic                      ref_clk,
	input  logic                      arst_n,
	input  logic                      sclk,
	input  logic                      cs_n,
	input  logic                      sdio_i,
	output logic                      sdio_o,
	output logic                      sdio_oe,
	output logic                      serial_out_pin,
	output logic                      serial_out_oe,
	input  logic                      scl_i,
	input  logic                      sda_i,
	output logic                      sda_o,
	output logic                      sda_oe,
	input  logic                      proto_strap,
	input  logic [6:0]                i2c_dev_addr,
	input  logic                      io_update_pin,
	output logic                      io_update_pulse,
	output logic                      i2c_mode,
	output logic [8*(2**MEM_AW)-1:0]  active_regs
);
	localparam int DEPTH = 2**MEM_AW;

	logic [7:0]  buf_q [DEPTH];
	logic [7:0]  act_q [DEPTH];
	logic        rbsel;
	// sclk domain
	spi_st_t     st_q;
	logic [3:0]  bit_q;
	logic [15:0] sh_q;
	instr_t      ins_q;
	logic [12:0] addr_q;
	logic [1:0]  left_q;
	logic [7:0]  tx_q;
	logic        out_q;
	logic        lsb_q;
	logic        uni_q;
	wr_t         wr_q;
	logic        wr_tgl_q;
	logic        frame_rst_n;
	logic        abort;
	logic [15:0] sh_d;
	logic [7:0]  byte_d;
	instr_t      ins_d;
	logic        byte_end;
	logic [12:0] addr_nx;
	logic        rd_act;
	// ref_clk domain
	logic [1:0]  strap_s;
	logic [2:0]  start_q;
	logic        i2c_mode_q;
	logic [2:0]  wt_s;
	logic [2:0]  up_s;
	logic        spi_wr;
	logic        pin_rise;
	logic [1:0]  ls0_q;
	logic [1:0]  ls1_q;
	logic [1:0]  f_q;
	logic [1:0]  pf_q;
	logic [2:0]  fc_q [2];
	logic        scl_rise;
	logic        scl_fall;
	logic        start;
	logic        stop;
	i2c_st_t     ist_q;
	logic [7:0]  ish_q;
	logic [3:0]  ibit_q;
	logic        irw_q;
	logic [1:0]  ibyte_q;
	logic [15:0] ptr_q;
	logic        isda_q;
	logic [7:0]  i2c_rd;
	logic        i2c_wr;
	logic        wr_en;
	logic [15:0] wa;
	logic [7:0]  wd;
	logic        wa_ok;
	logic        upd;
	logic        upd_q;

	function automatic logic [15:0] shift_in(input logic [15:0] s, input logic d,
		input logic lsb);
		return lsb ? {d, s[15:1]} : {s[14:0], d};
	endfunction

	function automatic logic [12:0] step(input logic [12:0] a, input logic lsb);
		return lsb ? a + 13'h0001 : a - 13'h0001;
	endfunction

	// unmapped addresses still return a byte, zero
	function automatic logic [7:0] mem_rd(input logic [15:0] a, input logic act);
		if ((a >> MEM_AW) != 16'h0000)
			return 8'h00;
		return act ? act_q[a[MEM_AW-1:0]] : buf_q[a[MEM_AW-1:0]];
	endfunction

	// port configuration lives in the SPI logic, not in the register array
	function automatic logic [7:0] spi_rd(input logic [12:0] a);
		logic [7:0] c;
		c = 8'h00;
		c[B_LSB] = lsb_q;
		c[B_UNI] = uni_q;
		if (a == A_CFG)
			return c;
		return mem_rd({3'h0, a}, rbsel);
	endfunction

	assign rbsel = buf_q[A_RBSEL[MEM_AW-1:0]][B_RBSEL];

	// only the long instruction form is decoded
	always_comb begin
		sh_d = shift_in(sh_q, sdio_i, lsb_q);
		byte_d = lsb_q ? sh_d[15:8] : sh_d[7:0];
		ins_d = instr_t'(sh_d);
		byte_end = (st_q == S_DATA) && (bit_q[2:0] == BYTE_LAST);
		addr_nx = step(addr_q, lsb_q);
	end

	// mid-byte, streaming end or finished frame: reset on chip select high
	// state feeding this is frozen while cs_n is high, so no glitch on release
	assign abort = (st_q == S_DONE) || (bit_q[2:0] != 3'h0) ||
		(st_q == S_DATA && ins_q.cnt == CNT_STREAM);
	assign frame_rst_n = arst_n & ~(cs_n & abort);

	// instruction then payload, stall keeps state across chip select
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			st_q <= S_INSTR;
			bit_q <= 4'h0;
			sh_q <= 16'h0000;
			ins_q <= '0;
			addr_q <= 13'h0000;
			left_q <= 2'h0;
			tx_q <= 8'h00;
		end else begin
			sh_q <= sh_d;
			unique case (st_q)
				S_INSTR: begin
					bit_q <= bit_q + 4'h1;
					if (bit_q == INSTR_LAST) begin
						ins_q <= ins_d;
						addr_q <= ins_d.addr;
						left_q <= ins_d.cnt;
						bit_q <= 4'h0;
						st_q <= S_DATA;
						tx_q <= spi_rd(ins_d.addr);
					end
				end
				S_DATA: begin
					bit_q <= {1'b0, bit_q[2:0] + 3'h1};
					tx_q <= lsb_q ? tx_q >> 1 : tx_q << 1;
					if (byte_end) begin
						// step one address per byte, no skipping
						addr_q <= addr_nx;
						tx_q <= spi_rd(addr_nx);
						left_q <= left_q - 2'h1;
						// fixed count ends, streaming never does
						if (ins_q.cnt != CNT_STREAM && left_q == 2'h0)
							st_q <= S_DONE;
					end
				end
				S_DONE: st_q <= S_DONE;
				default: st_q <= S_DONE;
			endcase
		end
	end

	// completed write bytes handed to ref_clk; config applied here
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			lsb_q <= 1'b0;
			uni_q <= 1'b0;
			wr_q <= '0;
			wr_tgl_q <= 1'b0;
		end else if (byte_end && !ins_q.rd && !cs_n) begin
			if (addr_q == A_CFG) begin
				lsb_q <= byte_d[B_LSB];
				uni_q <= byte_d[B_UNI];
			end else begin
				wr_q <= '{addr: {3'h0, addr_q}, data: byte_d};
				wr_tgl_q <= ~wr_tgl_q;
			end
		end
	end

	// read bits change on the falling edge
	always_ff @(negedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n)
			out_q <= 1'b0;
		else
			out_q <= lsb_q ? tx_q[0] : tx_q[7];
	end

	// floated while deselected; unidirectional moves data to its own pin
	assign rd_act = !cs_n && st_q == S_DATA && ins_q.rd && !i2c_mode_q;
	assign sdio_oe = rd_act && !uni_q;
	assign serial_out_oe = rd_act && uni_q;
	assign sdio_o = out_q;
	assign serial_out_pin = out_q;

	// protocol strap caught once, a few cycles after reset release
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_s <= 2'b00;
			start_q <= 3'b000;
			i2c_mode_q <= 1'b0;
		end else begin
			strap_s <= {strap_s[0], proto_strap};
			start_q <= {start_q[1:0], 1'b1};
			if (start_q == 3'b011)
				i2c_mode_q <= strap_s[1];
		end
	end
	assign i2c_mode = i2c_mode_q;

	// toggle crossing for SPI writes and synchroniser for the update pin
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wt_s <= 3'b000;
			up_s <= 3'b000;
		end else begin
			wt_s <= {wt_s[1:0], wr_tgl_q};
			up_s <= {up_s[1:0], io_update_pin};
		end
	end
	assign spi_wr = (wt_s[2] ^ wt_s[1]) && !i2c_mode_q;
	assign pin_rise = up_s[1] && !up_s[2];

	// two-wire inputs: sync, then need GLITCH_CYC agreeing samples to flip
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ls0_q <= 2'b11;
			ls1_q <= 2'b11;
			f_q <= 2'b11;
			pf_q <= 2'b11;
			fc_q[0] <= 3'h0;
			fc_q[1] <= 3'h0;
		end else begin
			ls0_q <= {sda_i, scl_i};
			ls1_q <= ls0_q;
			pf_q <= f_q;
			for (int i = 0; i < 2; i++) begin
				if (ls1_q[i] == f_q[i]) begin
					fc_q[i] <= 3'h0;
				end else if (fc_q[i] == 3'(GLITCH_CYC - 1)) begin
					f_q[i] <= ls1_q[i];
					fc_q[i] <= 3'h0;
				end else begin
					fc_q[i] <= fc_q[i] + 3'h1;
				end
			end
		end
	end
	assign scl_rise = f_q[0] && !pf_q[0];
	assign scl_fall = !f_q[0] && pf_q[0];
	assign start = pf_q[1] && !f_q[1] && f_q[0] && pf_q[0];
	assign stop = !pf_q[1] && f_q[1] && f_q[0] && pf_q[0];

	// byte at the pointer, named so its top bit can be picked out for the first read bit
	assign i2c_rd = mem_rd(ptr_q, rbsel);

	// two-wire slave; scl is never driven, only sda is pulled low
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ist_q <= I_IDLE;
			ish_q <= 8'h00;
			ibit_q <= 4'h0;
			irw_q <= 1'b0;
			ibyte_q <= 2'h0;
			ptr_q <= 16'h0000;
			isda_q <= 1'b0;
		end else if (!i2c_mode_q || stop) begin
			ist_q <= I_IDLE;
			isda_q <= 1'b0;
		end else if (start) begin
			ist_q <= I_ADDR;
			ibit_q <= 4'h0;
			ibyte_q <= 2'h0;
			isda_q <= 1'b0;
		end else begin
			unique case (ist_q)
				I_IDLE: ist_q <= I_IDLE;
				I_ADDR, I_RX: begin
					if (scl_rise) begin
						ish_q <= {ish_q[6:0], f_q[1]};
						ibit_q <= ibit_q + 4'h1;
					end
					if (scl_fall && ibit_q == I2C_NBITS) begin
						ibit_q <= 4'h0;
						isda_q <= 1'b1;
						ist_q <= I_ACK;
						if (ist_q == I_ADDR) begin
							// silent unless the address is ours
							irw_q <= ish_q[0];
							if (ish_q[7:1] != i2c_dev_addr) begin
								isda_q <= 1'b0;
								ist_q <= I_IDLE;
							end
						end else if (ibyte_q == 2'h0) begin
							ptr_q[15:8] <= ish_q;
							ibyte_q <= 2'h1;
						end else if (ibyte_q == 2'h1) begin
							ptr_q[7:0] <= ish_q;
							ibyte_q <= 2'h2;
						end else begin
							ptr_q <= ptr_q + 16'h0001;
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						isda_q <= 1'b0;
						ist_q <= I_RX;
						if (irw_q) begin
							ish_q <= i2c_rd;
							isda_q <= !i2c_rd[7];
							ist_q <= I_TX;
						end
					end
				end
				I_TX: begin
					if (scl_fall) begin
						ibit_q <= ibit_q + 4'h1;
						ish_q <= ish_q << 1;
						isda_q <= !ish_q[6];
						if (ibit_q == 4'h7) begin
							isda_q <= 1'b0;
							ptr_q <= ptr_q + 16'h0001;
							ibit_q <= 4'h0;
							ist_q <= I_TACK;
						end
					end
				end
				// master nack ends the read, ack fetches the next byte
				I_TACK: begin
					if (scl_rise)
						ist_q <= f_q[1] ? I_IDLE : I_ACK;
				end
				default: ist_q <= I_IDLE;
			endcase
		end
	end
	assign sda_oe = isda_q;
	assign sda_o = 1'b0;
	assign i2c_wr = ist_q == I_RX && scl_fall && ibit_q == I2C_NBITS && ibyte_q == 2'h2 &&
		i2c_mode_q && !start && !stop;

	// one write path for both ports; only one protocol is ever active
	always_comb begin
		wr_en = spi_wr || i2c_wr;
		wa = spi_wr ? wr_q.addr : ptr_q;
		wd = spi_wr ? wr_q.data : ish_q;
		wa_ok = (wa >> MEM_AW) == 16'h0000 && wa != {3'h0, A_IOUPD};
		upd = (wr_en && wa == {3'h0, A_IOUPD} && wd[B_IOUPD]) || pin_rise;
	end

	// update copies every buffer byte at once; the update bit is never stored
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				buf_q[i] <= 8'h00;
				act_q[i] <= 8'h00;
			end
			upd_q <= 1'b0;
		end else begin
			if (wr_en && wa_ok)
				buf_q[wa[MEM_AW-1:0]] <= wd;
			if (upd)
				act_q <= buf_q;
			upd_q <= upd;
		end
	end
	assign io_update_pulse = upd_q;

	always_comb begin
		for (int i = 0; i < DEPTH; i++)
			active_regs[8*i +: 8] = act_q[i];
	end

	AST_INSTR16: assert property (@(posedge sclk) disable iff (!frame_rst_n)
		st_q == S_INSTR && bit_q == INSTR_LAST |=> st_q == S_DATA && bit_q == 4'h0)
		else $error("instruction did not end after 16 bits");
	// an ended frame is reset before the next sclk edge, so only a frame that goes on is judged
	AST_STEP_DN: assert property (@(posedge sclk) disable iff (!frame_rst_n)
		(byte_end && !lsb_q) ##1 (st_q != S_INSTR) |-> addr_q == $past(addr_q) - 13'h0001)
		else $error("msb first address did not decrement");
	AST_STEP_UP: assert property (@(posedge sclk) disable iff (!frame_rst_n)
		(byte_end && lsb_q) ##1 (st_q != S_INSTR) |-> addr_q == $past(addr_q) + 13'h0001)
		else $error("lsb first address did not increment");
	AST_LAST_BYTE: assert property (@(posedge sclk) disable iff (!frame_rst_n)
		(byte_end && ins_q.cnt != CNT_STREAM && left_q == 2'h0) ##1 (st_q != S_INSTR) |->
		st_q == S_DONE)
		else $error("fixed count transfer did not finish");
	AST_HIZ: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cs_n |-> !sdio_oe && !serial_out_oe)
		else $error("data pin driven while deselected");
	AST_BUF_WR: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_en && wa_ok |=> buf_q[$past(wa[MEM_AW-1:0])] == $past(wd))
		else $error("buffer byte not written");
	AST_COPY: assert property (@(posedge ref_clk) disable iff (!arst_n)
		upd |=> act_q[0] == $past(buf_q[0]) && io_update_pulse)
		else $error("update did not copy buffer");
	AST_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!upd |=> act_q[0] == $past(act_q[0]))
		else $error("active register changed without update");
	AST_MODE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		start_q[2] |=> $stable(i2c_mode_q))
		else $error("protocol changed after startup");
	AST_GLITCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(f_q[0]) |-> $past(ls1_q[0], 1) && $past(ls1_q[0], 5))
		else $error("short clock pulse passed filter");
	AST_ADDR_NAK: assert property (@(posedge ref_clk) disable iff (!arst_n)
		ist_q == I_ADDR && scl_fall && ibit_q == I2C_NBITS && !start && !stop &&
		ish_q[7:1] != i2c_dev_addr |=> ist_q == I_IDLE && !sda_oe)
		else $error("answered a foreign address");
	AST_SLAVE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		sda_oe |-> ist_q == I_ACK || ist_q == I_TX)
		else $error("data line driven outside ack or read");

	COV_SPI_WR: cover property (@(posedge ref_clk) disable iff (!arst_n) spi_wr);
	COV_SPI_RD: cover property (@(posedge sclk) disable iff (!frame_rst_n) byte_end && ins_q.rd);
	COV_UPD: cover property (@(posedge ref_clk) disable iff (!arst_n) upd);
	COV_I2C_WR: cover property (@(posedge ref_clk) disable iff (!arst_n) i2c_wr);
endmodule

// File: core/scp_pkg.sv
// constants and types of the serial control port
// assumes one SPI host and one two-wire master, never both active
package scp_pkg;
	localparam int          ADDR_W     = 13;
	localparam logic [12:0] A_CFG      = 13'h0000;
	localparam logic [12:0] A_RBSEL    = 13'h0004;
	localparam logic [12:0] A_IOUPD    = 13'h0005;
	localparam int          B_LSB      = 6;
	localparam int          B_UNI      = 7;
	localparam int          B_RBSEL    = 0;
	localparam int          B_IOUPD    = 0;
	localparam logic [1:0]  CNT_STREAM = 2'h3;
	localparam logic [3:0]  INSTR_LAST = 4'hf;
	localparam logic [2:0]  BYTE_LAST  = 3'h7;
	localparam logic [3:0]  I2C_NBITS  = 4'h8;
	localparam int          REF_MHZ    = 100;
	localparam int          GLITCH_NS  = 50;
	// least time, so round up to whole reference cycles
	localparam int          GLITCH_CYC = (GLITCH_NS * REF_MHZ + 999) / 1000;

	typedef struct packed {
		logic        rd;
		logic [1:0]  cnt;
		logic [12:0] addr;
	} instr_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} wr_t;

	typedef enum logic [1:0] {
		S_INSTR = 2'b00,
		S_DATA  = 2'b01,
		S_DONE  = 2'b10
	} spi_st_t;

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_ACK  = 3'b010,
		I_RX   = 3'b011,
		I_TX   = 3'b100,
		I_TACK = 3'b101
	} i2c_st_t;
endpackage

// File: testbench/spi_host.sv
// SPI host model for the serial control port: clock, chip select, data out
// assumes the bench resolves the shared data wire from both enables
module spi_host
	import scp_pkg::*;
(
	output logic      sclk,
	output logic      cs_n,
	output logic      host_d,
	output logic      host_oe,
	input  wire logic sdio
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock stands low between frames, chip select idles high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_d = 1'b0;
		host_oe = 1'b0;
	end

	// sample on rising edge, order from lsb flag
	// data is released 1 ns after each rising edge; a read collides only in that 1 ns after the 16th rising edge
	task automatic bits(input logic [7:0] tx, input logic lsb, input logic drv,
		input int n, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		for (i = 0; i < n; i++) begin
			sclk = 1'b0;
			host_oe = drv;
			host_d = lsb ? tx[i % 8] : tx[7 - i % 8];
			#3;
			if (lsb) begin
				rx[i % 8] = sdio;
			end else begin
				rx[7 - i % 8] = sdio;
			end
			sclk = 1'b1;
			#1 host_oe = 1'b0;
			#2;
		end
	endtask

	task automatic stop();
		sclk = 1'b0;
		#3 cs_n = 1'b1;
		#12;
	endtask

	// optional stall per byte, no skipped bytes, cs ends a stream
	task automatic frame(input logic rd, input logic [1:0] cnt, input logic [12:0] a,
		input logic lsb, input int nb, input logic [7:0] wd [4],
		output logic [7:0] rq [4], input logic stall);
		logic [15:0] w;
		logic [7:0]  rx;
		int k;
		// count field handed in by the caller
		w = {rd, cnt, a};
		cs_n = 1'b0;
		#3;
		bits(lsb ? w[7:0] : w[15:8], lsb, 1'b1, 8, rx);
		bits(lsb ? w[15:8] : w[7:0], lsb, 1'b1, 8, rx);
		for (k = 0; k < nb; k++) begin
			if (stall) begin
				stop();
				cs_n = 1'b0;
				#3;
			end
			bits(wd[k], lsb, !rd, 8, rq[k]);
		end
		stop();
	endtask

	// chip select rises after n bits, off a byte boundary
	task automatic abort(input int n);
		logic [7:0] rx;
		cs_n = 1'b0;
		#3;
		bits(8'hff, 1'b0, 1'b1, n, rx);
		stop();
	endtask
endmodule

// File: testbench/testbench.sv
// self-checking bench for the serial control port, SPI first, then two-wire
// assumes the strap starts low; a late reset with the strap high selects two-wire
module testbench
	import scp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int AW = 6;
	// a quarter of a two-wire bit, longer than the input filter delay
	localparam int QTR = 100;
	logic ref_clk, arst_n, sclk, cs_n, host_d, host_oe, sdio, host_in;
	logic sdio_o, sdio_oe, serial_out_pin, serial_out_oe, io_update_pin, io_update_pulse;
	logic i2c_mode, seen_bi, seen_uni, strap, scl, sda, sda_lo, sda_oe;
	logic                 float_q = 1'b0;
	logic [8*(2**AW)-1:0] active_regs;
	logic [7:0]           rx_q [4];
	int                   n_errors = 0;
	int                   n_checks = 0;

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// released wire changes every cycle so a stale bit cannot pass
	always @(posedge ref_clk) float_q <= ~float_q;
	assign sdio = (sdio_oe && host_oe) ? 1'bx : sdio_oe ? sdio_o : host_oe ? host_d : float_q;
	// host listens on the separate pin while the device drives it
	assign host_in = serial_out_oe ? serial_out_pin : sdio;
	// open-drain data line with pull-up
	assign sda = !(sda_lo || sda_oe);
	always @(sdio_oe or serial_out_oe) begin
		if (sdio_oe === 1'b1) seen_bi = 1'b1;
		if (serial_out_oe === 1'b1) seen_uni = 1'b1;
	end

	scp_core #(.MEM_AW(AW)) dut_u (
		.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio),
		.sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.proto_strap(strap), .i2c_dev_addr(7'h2a), .io_update_pin(io_update_pin),
		.io_update_pulse(io_update_pulse), .i2c_mode(i2c_mode), .active_regs(active_regs)
	);

	spi_host host_u (.sclk(sclk), .cs_n(cs_n), .host_d(host_d), .host_oe(host_oe),
		.sdio(host_in));

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	function automatic logic [7:0] act(input int a);
		return active_regs[8*a +: 8];
	endfunction

	task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [12:0] a,
		input logic lsb, input int nb, input logic [7:0] wd [4], input logic stall);
		@(posedge ref_clk) #1;
		host_u.frame(rd, cnt, a, lsb, nb, wd, rx_q, stall);
	endtask

	// bounded wait for the copy pulse; running out ends the run
	task automatic wait_pulse();
		int i;
		for (i = 0; i < 30; i++) begin
			@(posedge ref_clk) #1;
			if (io_update_pulse === 1'b1) break;
		end
		if (i == 30) begin
			n_errors++;
			$display("mismatch io_update_pulse expected 1 seen 0");
			results();
		end
	endtask

	task automatic t_reset();
		check_bit("active_regs zero", 1'b1, active_regs === '0);
		check_bit("sdio_oe idle", 1'b0, sdio_oe);
		check_bit("serial_out_oe idle", 1'b0, serial_out_oe);
		check_bit("i2c_mode", 1'b0, i2c_mode);
		$display("test reset done");
	endtask

	task automatic t_update();
		xfer(1'b0, 2'b00, 13'h0010, 1'b0, 2, '{8'ha5, 8'hee, 8'h00, 8'h00}, 1'b0);
		repeat (8) @(posedge ref_clk);
		check_byte("active before update", 8'h00, act(16));
		xfer(1'b0, 2'b00, A_IOUPD, 1'b0, 1, '{8'h01, 8'h00, 8'h00, 8'h00}, 1'b0);
		wait_pulse();
		check_byte("active after update", 8'ha5, act(16));
		check_byte("byte past count", 8'h00, act(15));
		xfer(1'b1, 2'b00, A_IOUPD, 1'b0, 1, '{default: 8'h00}, 1'b0);
		check_byte("update bit readback", 8'h00, rx_q[0]);
		$display("test update done");
	endtask

	task automatic t_stall();
		xfer(1'b0, 2'b10, 13'h0012, 1'b0, 3, '{8'h11, 8'h22, 8'h33, 8'h00}, 1'b1);
		repeat (6) @(posedge ref_clk);
		#1 io_update_pin = 1'b1;
		wait_pulse();
		io_update_pin = 1'b0;
		check_byte("stall byte 0x12", 8'h11, act(18));
		check_byte("stall byte 0x11", 8'h22, act(17));
		check_byte("stall byte 0x10", 8'h33, act(16));
		$display("test stall done");
	endtask

	task automatic t_read();
		xfer(1'b0, 2'b00, 13'h0010, 1'b0, 1, '{8'h5a, 8'h00, 8'h00, 8'h00}, 1'b0);
		seen_bi = 1'b0;
		xfer(1'b1, 2'b10, 13'h0012, 1'b0, 3, '{default: 8'h00}, 1'b0);
		check_byte("read 0x12", 8'h11, rx_q[0]);
		check_byte("read 0x11", 8'h22, rx_q[1]);
		check_byte("read buffer 0x10", 8'h5a, rx_q[2]);
		check_bit("sdio driven", 1'b1, seen_bi);
		check_bit("separate output unused", 1'b0, seen_uni);
		check_bit("sdio released", 1'b0, sdio_oe);
		check_bit("separate output released", 1'b0, serial_out_oe);
		xfer(1'b0, 2'b00, A_RBSEL, 1'b0, 1, '{8'h01, 8'h00, 8'h00, 8'h00}, 1'b0);
		repeat (6) @(posedge ref_clk);
		xfer(1'b1, 2'b00, 13'h0010, 1'b0, 1, '{default: 8'h00}, 1'b0);
		check_byte("read active 0x10", 8'h33, rx_q[0]);
		// unidirectional: read data leaves on the separate pin only
		xfer(1'b0, 2'b00, A_CFG, 1'b0, 1, '{8'h80, 8'h00, 8'h00, 8'h00}, 1'b0);
		seen_bi = 1'b0;
		xfer(1'b1, 2'b00, 13'h0011, 1'b0, 1, '{default: 8'h00}, 1'b0);
		check_byte("read separate pin 0x11", 8'h22, rx_q[0]);
		check_bit("separate output driven", 1'b1, seen_uni);
		check_bit("sdio quiet", 1'b0, seen_bi);
		$display("test read done");
	endtask

	task automatic t_abort();
		@(posedge ref_clk) #1;
		host_u.abort(5);
		host_u.abort(13);
		xfer(1'b0, 2'b00, 13'h0008, 1'b0, 1, '{8'h77, 8'h00, 8'h00, 8'h00}, 1'b0);
		xfer(1'b0, 2'b00, A_IOUPD, 1'b0, 1, '{8'h01, 8'h00, 8'h00, 8'h00}, 1'b0);
		wait_pulse();
		check_byte("write after abort", 8'h77, act(8));
		$display("test abort done");
	endtask

	task automatic t_lsb();
		int i;
		xfer(1'b0, 2'b00, A_CFG, 1'b0, 1, '{8'h40, 8'h00, 8'h00, 8'h00}, 1'b0);
		xfer(1'b0, CNT_STREAM, 13'h0020, 1'b1, 4, '{8'h01, 8'h02, 8'h03, 8'h04}, 1'b0);
		xfer(1'b0, 2'b00, A_IOUPD, 1'b1, 1, '{8'h01, 8'h00, 8'h00, 8'h00}, 1'b0);
		wait_pulse();
		for (i = 0; i < 4; i++) begin
			check_byte("stream byte", 8'(i + 1), act(32 + i));
		end
		check_byte("past stream end", 8'h00, act(36));
		check_byte("below stream start", 8'h00, act(31));
		$display("test lsb done");
	endtask

	// two-wire master: start, stop and one byte with its ninth clock
	task automatic i2c_start();
		scl = 1'b0;
		#QTR sda_lo = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_lo = 1'b1;
		#QTR;
	endtask

	task automatic i2c_stop();
		scl = 1'b0;
		#QTR sda_lo = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_lo = 1'b0;
		#QTR;
	endtask

	// line released on the ninth clock; ack is the low level seen there
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		int i;
		ack = 1'b0;
		for (i = 0; i < 9; i++) begin
			scl = 1'b0;
			#QTR sda_lo = (i < 8) && !b[7 - i];
			#QTR scl = 1'b1;
			#QTR ack = !sda;
			#QTR;
		end
	endtask

	// strap is ignored until the next reset, which then selects two-wire
	task automatic t_i2c();
		logic ack;
		@(posedge ref_clk) #1;
		strap = 1'b1;
		repeat (6) @(posedge ref_clk);
		check_bit("i2c_mode before reset", 1'b0, i2c_mode);
		#1 arst_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		repeat (8) @(posedge ref_clk);
		#1 check_bit("i2c_mode after reset", 1'b1, i2c_mode);
		i2c_start();
		i2c_byte(8'h56, ack);
		check_bit("foreign address ack", 1'b0, ack);
		i2c_stop();
		i2c_start();
		i2c_byte(8'h54, ack);
		check_bit("own address ack", 1'b1, ack);
		i2c_byte(8'h00, ack);
		i2c_byte(8'h16, ack);
		i2c_byte(8'hc3, ack);
		check_bit("data ack", 1'b1, ack);
		i2c_stop();
		check_bit("sda released", 1'b0, sda_oe);
		@(posedge ref_clk) #1 io_update_pin = 1'b1;
		wait_pulse();
		io_update_pin = 1'b0;
		check_byte("two-wire write 0x16", 8'hc3, act(22));
		$display("test i2c done");
	endtask

	initial begin
		arst_n = 1'b0;
		io_update_pin = 1'b0;
		strap = 1'b0;
		scl = 1'b1;
		sda_lo = 1'b0;
		seen_bi = 1'b0;
		seen_uni = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		repeat (8) @(posedge ref_clk);
		t_reset();
		t_update();
		t_stall();
		t_read();
		t_abort();
		t_lsb();
		t_i2c();
		results();
	end
endmodule
